// ### timer_channel_capture_core.sv
/*
  three 16-bit timer channels with clock select, gating, clock control,
  triggers and dual capture. assumes every input is already synchronous
  to i_sys_clk; external clocks and triggers are sampled on that clock.
*/
`timescale 1ns/1ps

module timer_channel_capture_core
  import timer_pkg::*;
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_slow_clock,
  input  wire logic [2:0]           i_ext_clock_pin,
  input  wire logic [1:0]           i_route_sel [3],
  input  wire logic                 i_block_sync,
  input  wire logic [2:0]           i_clock_source_select [3],
  input  wire logic [2:0]           i_clock_invert,
  input  wire logic [1:0]           i_clock_gate_select [3],
  input  wire logic [2:0]           i_wave_mode,
  input  wire logic [2:0]           i_clock_enable_cmd,
  input  wire logic [2:0]           i_clock_disable_cmd,
  input  wire logic [2:0]           i_soft_trigger_cmd,
  input  wire logic [2:0]           i_second_capture_load_disable,
  input  wire logic [2:0]           i_period_compare_disable,
  input  wire logic [2:0]           i_second_capture_load_halt,
  input  wire logic [2:0]           i_period_compare_halt,
  input  wire logic [2:0]           i_period_compare_trigger_en,
  input  wire logic [15:0]          i_period_compare_reg [3],
  input  wire logic [2:0]           i_cap_trig_on_line_a,
  input  wire logic [1:0]           i_ext_trigger_edge [3],
  input  wire logic [1:0]           i_ext_event_select [3],
  input  wire logic [2:0]           i_ext_event_trigger_en,
  input  wire logic [1:0]           i_first_load_edge [3],
  input  wire logic [1:0]           i_second_load_edge [3],
  input  wire logic [2:0]           i_status_read,
  input  wire logic [2:0]           i_first_capture_read,
  input  wire logic [2:0]           i_second_capture_read,
  input  wire logic [2:0]           i_io_line_a_in,
  input  wire logic [2:0]           i_io_line_b_in,
  input  wire logic [2:0]           i_io_line_a_wave,
  input  wire logic [2:0]           i_io_line_b_wave,
  output logic      [15:0]          o_counter_value [3],
  output logic      [15:0]          o_first_capture_reg [3],
  output logic      [15:0]          o_second_capture_reg [3],
  output logic      [2:0]           o_counter_overflow_flag,
  output logic      [2:0]           o_load_overrun_flag,
  output logic      [2:0]           o_clock_running_flag,
  output logic      [2:0]           o_clock_started,
  output logic      [2:0]           o_io_line_a_out,
  output logic      [2:0]           o_io_line_a_oe,
  output logic      [2:0]           o_io_line_b_out,
  output logic      [2:0]           o_io_line_b_oe
);
  import timer_pkg::*;

  // ==========================================================
  // state
  timer_s state_r;
  timer_s state_nxt;

  // divided master clock levels and the resampled slow clock
  logic [PRE_W-1:0] pre_next;
  logic [4:0]       int_clk;
  logic [2:0]       xc [3];

  // prescaler rolls freely; internal clocks 1-4 are its counter bits as levels, 5 is the slow clock
  always_comb begin
    pre_next = state_r.prescale + 7'h01;
    int_clk[0] = state_r.prescale[DIV2_BIT];
    int_clk[1] = state_r.prescale[DIV8_BIT];
    int_clk[2] = state_r.prescale[DIV32_BIT];
    int_clk[3] = state_r.prescale[DIV128_BIT];
    int_clk[4] = state_r.slow_prev[1];
  end

  // ==========================================================
  // external clock routing: pin or another channel's line a
  // route code 1 is unused and reads as all zeros, so a channel
  // left on it sees no external clock at all
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_route
      always_comb begin
        logic [2:0] la;
        la = i_io_line_a_in;
        case (i_route_sel[g])
          ROUTE_PIN:  xc[g] = {i_ext_clock_pin[2], i_ext_clock_pin[1], i_ext_clock_pin[0]};
          ROUTE_ALT1: xc[g] = {la[(g+2)%3], la[(g+2)%3], la[(g+1)%3]};
          ROUTE_ALT2: xc[g] = {la[(g+1)%3], la[(g+2)%3], la[(g+2)%3]};
          default:    xc[g] = 3'h0;
        endcase
      end
    end
  endgenerate

  // ==========================================================
  // per-channel next-state
  always_comb begin
    state_nxt = state_r;
    state_nxt.prescale = pre_next;
    state_nxt.slow_prev = {state_r.slow_prev[1:0], i_slow_clock};
    for (int c = 0; c < NUM_CH; c++) begin
      logic       sel_clk;
      logic       gate;
      logic       tick;
      logic       la_rise;
      logic       la_fall;
      logic       lb_rise;
      logic       lb_fall;
      logic       evt;
      logic       evt_hit;
      logic       trig;
      logic       match;
      logic       ld_a;
      logic       ld_b;
      logic       stop;
      logic [1:0] tedge;
      chan_s      s;

      // defaults first so no path leaves a temporary undriven
      sel_clk = 1'b0;
      gate    = 1'b1;
      evt     = 1'b0;
      s       = state_r.ch[c];

      // ------------------------------------------------------
      // clock select, invert, gate
      // the selected clock is a level sampled on i_sys_clk;
      // its rising edge is found against the copy held in clk_prev,
      // so an external clock must hold each level one full period
      case (i_clock_source_select[c])
        SRC_INT1: sel_clk = int_clk[0];
        SRC_INT2: sel_clk = int_clk[1];
        SRC_INT3: sel_clk = int_clk[2];
        SRC_INT4: sel_clk = int_clk[3];
        SRC_INT5: sel_clk = int_clk[4];
        SRC_XC0:  sel_clk = xc[c][0];
        SRC_XC1:  sel_clk = xc[c][1];
        default:  sel_clk = xc[c][2];
      endcase
      sel_clk = sel_clk ^ i_clock_invert[c];
      case (i_clock_gate_select[c])
        GATE_XC0: gate = xc[c][0];
        GATE_XC1: gate = xc[c][1];
        GATE_XC2: gate = xc[c][2];
        default:  gate = 1'b1;
      endcase

      // ------------------------------------------------------
      // a tick needs enable and run both set, so a disabled or
      // stopped clock freezes the count without losing its value
      // active edge of selected clock, qualified by run and gate
      tick = sel_clk & ~s.clk_prev & gate & s.clk_en & s.clk_run;
      state_nxt.ch[c].clk_prev = sel_clk;

      // ------------------------------------------------------
      // line edges for capture and trigger
      // both lines keep a registered copy; an edge is a difference
      // between the pin now and that copy
      la_rise = i_io_line_a_in[c] & ~s.line_a_prev;
      la_fall = ~i_io_line_a_in[c] & s.line_a_prev;
      lb_rise = i_io_line_b_in[c] & ~s.line_b_prev;
      lb_fall = ~i_io_line_b_in[c] & s.line_b_prev;
      state_nxt.ch[c].line_a_prev = i_io_line_a_in[c];
      state_nxt.ch[c].line_b_prev = i_io_line_b_in[c];

      // ------------------------------------------------------
      // external trigger source depends on mode
      // waveform picks line b or an external select and only fires
      // when the event trigger enable is set; capture picks a or b
      if (i_wave_mode[c]) begin
        case (i_ext_event_select[c])
          EVT_XC0: evt = xc[c][0];
          EVT_XC1: evt = xc[c][1];
          EVT_XC2: evt = xc[c][2];
          default: evt = i_io_line_b_in[c];
        endcase
      end else begin
        evt = i_cap_trig_on_line_a[c] ? i_io_line_a_in[c] : i_io_line_b_in[c];
      end
      state_nxt.ch[c].evt_prev = evt;
      tedge = i_ext_trigger_edge[c];
      evt_hit = ((tedge == EDGE_RISE || tedge == EDGE_BOTH) & evt & ~s.evt_prev) |
                ((tedge == EDGE_FALL || tedge == EDGE_BOTH) & ~evt & s.evt_prev);
      if (i_wave_mode[c] && !i_ext_event_trigger_en[c]) begin
        evt_hit = 1'b0;
      end

      // compare holds while the count sits on the value, so a slow
      // clock repeats the trigger; one still seen at the clearing tick re-marks it, so zero holds for one more tick
      match = (s.count == i_period_compare_reg[c]);
      // any trigger source
      // software, block sync, external event and period match all
      // land on the same pending-clear path
      trig = i_soft_trigger_cmd[c] | i_block_sync | evt_hit |
             (match & i_period_compare_trigger_en[c]);

      // ------------------------------------------------------
      // capture loads with sequencing
      // first register waits for the second after its own load; the
      // second needs one first load since the last trigger or reset, then reloads on each edge; a trigger resets both sequences
      ld_a = 1'b0;
      ld_b = 1'b0;
      if (!i_wave_mode[c]) begin
        ld_a = ((i_first_load_edge[c] == EDGE_RISE || i_first_load_edge[c] == EDGE_BOTH)
                & la_rise) |
               ((i_first_load_edge[c] == EDGE_FALL || i_first_load_edge[c] == EDGE_BOTH)
                & la_fall);
        ld_b = ((i_second_load_edge[c] == EDGE_RISE || i_second_load_edge[c] == EDGE_BOTH)
                & la_rise) |
               ((i_second_load_edge[c] == EDGE_FALL || i_second_load_edge[c] == EDGE_BOTH)
                & la_fall);
        ld_a = ld_a & (~s.a_loaded | s.b_loaded);
        ld_b = ld_b & s.a_loaded & ~ld_a;
      end

      // ------------------------------------------------------
      // read side effects first, so a same-cycle event wins
      // a flag set and its read in one cycle leaves the flag set,
      // so software never loses an event it has not yet seen
      if (i_status_read[c]) begin
        state_nxt.ch[c].ovf_flag = 1'b0;
        state_nxt.ch[c].ovr_flag = 1'b0;
      end
      if (i_first_capture_read[c]) state_nxt.ch[c].a_unread = 1'b0;
      if (i_second_capture_read[c]) state_nxt.ch[c].b_unread = 1'b0;
      if (ld_a) begin
        state_nxt.ch[c].cap_a = s.count;
        state_nxt.ch[c].a_loaded = 1'b1;
        state_nxt.ch[c].b_loaded = 1'b0;
        state_nxt.ch[c].a_unread = 1'b1;
        if (s.a_unread) state_nxt.ch[c].ovr_flag = 1'b1;
      end
      if (ld_b) begin
        state_nxt.ch[c].cap_b = s.count;
        state_nxt.ch[c].b_loaded = 1'b1;
        state_nxt.ch[c].b_unread = 1'b1;
        if (s.b_unread) state_nxt.ch[c].ovr_flag = 1'b1;
      end

      // ------------------------------------------------------
      // stop events: second load in capture, period match in waveform
      stop = i_wave_mode[c] ? (match & i_period_compare_halt[c])
                            : (ld_b & i_second_capture_load_halt[c]);

      // ------------------------------------------------------
      // counting and trigger-pending clear at next active edge
      // a trigger only marks the clear; the count stays readable and
      // unchanged until the selected clock next rises
      if (trig) begin
        state_nxt.ch[c].trig_pend = 1'b1;
        state_nxt.ch[c].a_loaded = 1'b0;
        state_nxt.ch[c].b_loaded = 1'b0;
      end
      if (tick) begin
        if (s.trig_pend) begin
          state_nxt.ch[c].count = CNT_ZERO;
          state_nxt.ch[c].trig_pend = trig;
        end else begin
          state_nxt.ch[c].count = s.count + 16'h0001;
          if (s.count == CNT_MAX) state_nxt.ch[c].ovf_flag = 1'b1;
        end
      end

      // start/stop only while enabled; trigger start wins over stop
      if (s.clk_en) begin
        if (stop) state_nxt.ch[c].clk_run = 1'b0;
        if (trig) state_nxt.ch[c].clk_run = 1'b1;
      end

      // enable/disable commands and automatic disable
      // disable outranks enable so a same-cycle pair leaves it off
      if (i_clock_disable_cmd[c] ||
          (!i_wave_mode[c] && ld_b && i_second_capture_load_disable[c]) ||
          (i_wave_mode[c] && match && i_period_compare_disable[c])) begin
        state_nxt.ch[c].clk_en = 1'b0;
      end else if (i_clock_enable_cmd[c]) begin
        state_nxt.ch[c].clk_en = 1'b1;
      end
    end
  end

  // ==========================================================
  // state register
  // synchronous active-low reset clears every channel to idle
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // outputs
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_out
      assign o_counter_value[g]         = state_r.ch[g].count;
      assign o_first_capture_reg[g]     = state_r.ch[g].cap_a;
      assign o_second_capture_reg[g]    = state_r.ch[g].cap_b;
      assign o_counter_overflow_flag[g] = state_r.ch[g].ovf_flag;
      assign o_load_overrun_flag[g]     = state_r.ch[g].ovr_flag;
      assign o_clock_running_flag[g]    = state_r.ch[g].clk_en;
      assign o_clock_started[g]         = state_r.ch[g].clk_run;
      // line drivers by mode
      // oe is high while the core drives the line
      assign o_io_line_a_out[g] = i_io_line_a_wave[g];
      assign o_io_line_a_oe[g]  = i_wave_mode[g];
      assign o_io_line_b_out[g] = i_io_line_b_wave[g];
      assign o_io_line_b_oe[g]  = i_wave_mode[g] &
                                  ~(i_ext_event_trigger_en[g] &
                                    (i_ext_event_select[g] == EVT_LINE_B));
    end
  endgenerate
endmodule

// ### timer_pkg.sv
/*
  shared constants and types for the three-channel capture timer core.
  assumes a single system clock; all other inputs are synchronous to it.
*/
package timer_pkg;
  // ==========================================================
  // widths and counts
  localparam int          NUM_CH     = 3;
  localparam int          CNT_W      = 16;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam int          PRE_W      = 7;
  // master-clock divider taps: /2, /8, /32, /128
  localparam int          DIV2_BIT   = 0;
  localparam int          DIV8_BIT   = 2;
  localparam int          DIV32_BIT  = 4;
  localparam int          DIV128_BIT = 6;

  // ==========================================================
  // clock source select codes
  localparam logic [2:0] SRC_INT1 = 3'h0;
  localparam logic [2:0] SRC_INT2 = 3'h1;
  localparam logic [2:0] SRC_INT3 = 3'h2;
  localparam logic [2:0] SRC_INT4 = 3'h3;
  localparam logic [2:0] SRC_INT5 = 3'h4;
  localparam logic [2:0] SRC_XC0  = 3'h5;
  localparam logic [2:0] SRC_XC1  = 3'h6;
  localparam logic [2:0] SRC_XC2  = 3'h7;

  // gate select codes
  localparam logic [1:0] GATE_NONE = 2'h0;
  localparam logic [1:0] GATE_XC0  = 2'h1;
  localparam logic [1:0] GATE_XC1  = 2'h2;
  localparam logic [1:0] GATE_XC2  = 2'h3;

  // edge choices for loads and external triggers
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // waveform external event source codes
  localparam logic [1:0] EVT_LINE_B = 2'h0;
  localparam logic [1:0] EVT_XC0    = 2'h1;
  localparam logic [1:0] EVT_XC1    = 2'h2;
  localparam logic [1:0] EVT_XC2    = 2'h3;

  // per-channel external clock routing codes
  localparam logic [1:0] ROUTE_PIN  = 2'h0;
  localparam logic [1:0] ROUTE_ALT1 = 2'h2;
  localparam logic [1:0] ROUTE_ALT2 = 2'h3;

  // per-channel state
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] cap_a;
    logic [15:0] cap_b;
    logic        clk_en;
    logic        clk_run;
    logic        trig_pend;
    logic        a_loaded;
    logic        b_loaded;
    logic        a_unread;
    logic        b_unread;
    logic        ovf_flag;
    logic        ovr_flag;
    logic        clk_prev;
    logic        line_a_prev;
    logic        line_b_prev;
    logic        evt_prev;
  } chan_s;

  // whole-block state
  typedef struct packed {
    logic [PRE_W-1:0] prescale;
    logic [2:0]       slow_prev;
    chan_s [2:0]      ch;
  } timer_s;
endpackage

// ### timer_source_model.sv
/*
  far-side sources: three external clock pins and the slow clock.
  assumes i_sys_clk is the 200 MHz master clock of the core.
*/
`timescale 1ns/1ps
// ==========================================================
// clock sources
module timer_source_model (
  input  wire logic       i_sys_clk,
  output logic      [2:0] o_ext_clock_pin,
  output logic            o_slow_clock
);
  logic [6:0] phase_r = 7'h00;
  // 80-cycle phase counter; pins at /4, /8, /16, slow clock at /80
  always @(posedge i_sys_clk) begin
    phase_r <= (phase_r == 7'h4f) ? 7'h00 : phase_r + 7'h01;
  end
  // each level lasts two or more master periods, rate at most /4
  assign o_ext_clock_pin = {phase_r[3], phase_r[2], phase_r[1]};
  assign o_slow_clock    = (phase_r >= 7'h28);
endmodule

// ### timer_channel_capture_core_monitor.sv
/*
  port-level checks of the capture timer core, channel 0 in detail.
  assumes the bind below attaches it to every core instance.
*/
`timescale 1ns/1ps
// ==========================================================
// checker
module timer_channel_capture_core_monitor (
  input wire logic        i_sys_clk,
  input wire logic        i_resetn,
  input wire logic        i_block_sync,
  input wire logic [2:0]  i_wave_mode,
  input wire logic [2:0]  i_clock_enable_cmd,
  input wire logic [2:0]  i_clock_disable_cmd,
  input wire logic [2:0]  i_soft_trigger_cmd,
  input wire logic [2:0]  i_second_capture_load_halt,
  input wire logic [2:0]  i_period_compare_halt,
  input wire logic [2:0]  i_status_read,
  input wire logic [15:0] o_counter_value [3],
  input wire logic [2:0]  o_counter_overflow_flag,
  input wire logic [2:0]  o_clock_running_flag,
  input wire logic [2:0]  o_clock_started,
  input wire logic [2:0]  o_io_line_a_oe,
  input wire logic [2:0]  o_io_line_b_oe
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // reset, clock control and triggers
  reset_state_a: assert property ($rose(i_resetn) |-> o_clock_running_flag == 3'h0
    && o_counter_value[0] == 16'h0000) else $error("state not cleared by reset");
  enable_sets_a: assert property (i_clock_enable_cmd[0] && !i_clock_disable_cmd[0]
    |=> o_clock_running_flag[0]) else $error("enable did not set running flag");
  disable_clears_a: assert property (i_clock_disable_cmd[0]
    |=> !o_clock_running_flag[0]) else $error("disable left running flag set");
  stays_off_a: assert property (!o_clock_running_flag[0] && !i_clock_enable_cmd[0]
    |=> !o_clock_running_flag[0]) else $error("clock re-enabled without command");
  start_needs_en_a: assert property ($rose(o_clock_started[0])
    |-> o_clock_running_flag[0]) else $error("started while disabled");
  soft_start_a: assert property (i_soft_trigger_cmd[0] && o_clock_running_flag[0]
    && !i_clock_disable_cmd[0] && !i_second_capture_load_halt[0] && !i_period_compare_halt[0]
    |=> o_clock_started[0]) else $error("soft trigger did not start clock");
  sync_all_a: assert property (i_block_sync && &o_clock_running_flag
    && i_clock_disable_cmd == 3'h0 && i_second_capture_load_halt == 3'h0
    |=> o_clock_started == 3'h7) else $error("sync did not start all channels");
  // counting and flags
  count_step_a: assert property ($changed(o_counter_value[0]) |->
    o_counter_value[0] == $past(o_counter_value[0]) + 16'h0001
    || o_counter_value[0] == 16'h0000) else $error("count moved by other than one");
  wrap_flag_a: assert property ($changed(o_counter_value[0]) && o_counter_value[0] == 16'h0000
    && $past(o_counter_value[0]) == 16'hFFFF |-> ##[0:1] o_counter_overflow_flag[0])
    else $error("wrap did not set overflow flag");
  flag_sticky_a: assert property (o_counter_overflow_flag[0] && !i_status_read[0]
    |=> o_counter_overflow_flag[0]) else $error("overflow flag lost without read");
  read_clears_a: assert property (i_status_read[0] |=> !o_counter_overflow_flag[0]
    || o_counter_value[0] == 16'h0000) else $error("status read left overflow set");
  // line directions
  capture_inputs_a: assert property (!i_wave_mode[0]
    |-> !o_io_line_a_oe[0] && !o_io_line_b_oe[0]) else $error("line driven in capture");
  wave_drives_a: assert property (i_wave_mode[0]
    |-> o_io_line_a_oe[0]) else $error("line a not driven in waveform");
endmodule

bind timer_channel_capture_core timer_channel_capture_core_monitor i_mon (.*);

// ### timer_channel_capture_core_test.sv
/*
  self-checking bench for the three-channel capture timer core.
  assumes the source model drives the clock pins and slow clock.
*/
`timescale 1ns/1ps
module timer_channel_capture_core_test;
  import timer_pkg::*;
  logic        i_sys_clk = 1'b0, i_resetn = 1'b0, i_block_sync, i_slow_clock;
  logic [2:0]  i_ext_clock_pin, i_clock_invert, i_wave_mode, i_clock_enable_cmd;
  logic [2:0]  i_clock_disable_cmd, i_soft_trigger_cmd, i_second_capture_load_disable;
  logic [2:0]  i_period_compare_disable, i_second_capture_load_halt, i_period_compare_halt;
  logic [2:0]  i_period_compare_trigger_en, i_cap_trig_on_line_a, i_ext_event_trigger_en;
  logic [2:0]  i_status_read, i_first_capture_read, i_second_capture_read, i_io_line_a_in;
  logic [2:0]  i_io_line_b_in, i_io_line_a_wave, i_io_line_b_wave;
  logic [1:0]  i_route_sel [3], i_clock_gate_select [3], i_ext_trigger_edge [3];
  logic [1:0]  i_ext_event_select [3], i_first_load_edge [3], i_second_load_edge [3];
  logic [2:0]  i_clock_source_select [3];
  logic [15:0] i_period_compare_reg [3], o_counter_value [3];
  logic [15:0] o_first_capture_reg [3], o_second_capture_reg [3];
  logic [2:0]  o_counter_overflow_flag, o_load_overrun_flag, o_clock_running_flag;
  logic [2:0]  o_clock_started, o_io_line_a_out, o_io_line_a_oe;
  logic [2:0]  o_io_line_b_out, o_io_line_b_oe;
  logic [20:0] pulses = 21'h00_0000;
  logic [15:0] d;
  int          errors = 0, tests_run = 0, cyc = 0, seed = 62419, w;
  // rows: source, gate, route, count gained in 640 cycles
  int          tab [12][4] = '{'{5, 0, 1, 0}, '{5, 0, 2, 80}, '{5, 0, 3, 80},
    '{0, 3, 0, 160}, '{0, 0, 0, 320}, '{1, 0, 0, 80}, '{2, 0, 0, 20}, '{3, 0, 0, 5},
    '{4, 0, 0, 8}, '{5, 0, 0, 160}, '{6, 0, 0, 80}, '{7, 0, 0, 40}};

  timer_channel_capture_core i_dut (.*);
  timer_source_model i_src (.i_sys_clk(i_sys_clk), .o_ext_clock_pin(i_ext_clock_pin),
    .o_slow_clock(i_slow_clock));

  // ==========================================================
  // clock, command pulses, chained line a, timeout
  always #2.5 i_sys_clk = ~i_sys_clk;
  assign {i_block_sync, i_clock_enable_cmd, i_soft_trigger_cmd, i_clock_disable_cmd,
    i_first_capture_read, i_second_capture_read, i_status_read} = pulses[18:0];
  always @(posedge i_sys_clk) i_io_line_a_in[2:1] <= {2{i_ext_clock_pin[1]}};
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      wrap_up();
    end
  end

  task tick;
    @(posedge i_sys_clk);
    #1;
  endtask
  // k: 0 status read, 1/2 capture reads, 3 disable, 4 trigger, 5 enable, 6 sync
  task cmd(input int k);
    pulses = 21'h00_0007 << (3 * k);
    tick;
    pulses = 21'h00_0000;
    tick;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t ns: got %0h, expected %0h", $time, seen, exp);
    end
  endtask
  task delta(input int n, output logic [15:0] dd);
    logic [15:0] c0;
    c0 = o_counter_value[0];
    repeat (n) tick;
    dd = o_counter_value[0] - c0;
  endtask
  // pulse on line a of channel 0, aligned to the pin 0 clock
  task linea(input int hi);
    @(posedge i_ext_clock_pin[0]);
    #1;
    i_io_line_a_in[0] = 1'b1;
    repeat (hi) tick;
    i_io_line_a_in[0] = 1'b0;
    repeat (12) tick;
  endtask
  task wrap_up;
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {i_clock_invert, i_wave_mode, i_second_capture_load_disable, i_period_compare_disable,
     i_second_capture_load_halt, i_period_compare_halt, i_period_compare_trigger_en,
     i_cap_trig_on_line_a, i_ext_event_trigger_en, i_io_line_a_in, i_io_line_b_in,
     i_io_line_a_wave, i_io_line_b_wave} = '0;
    for (int c = 0; c < 3; c++) begin
      {i_route_sel[c], i_clock_gate_select[c], i_ext_trigger_edge[c]} = '0;
      {i_first_load_edge[c], i_second_load_edge[c], i_clock_source_select[c]} = '0;
      i_ext_event_select[c] = EVT_XC0;
      i_period_compare_reg[c] = 16'hFFFF;
    end
    repeat (10) tick;
    i_resetn = 1'b1;
    tick;
    chk(o_clock_running_flag, 0);
    cmd(5);
    chk(o_clock_running_flag, 7);
    // every clock source and routing choice, and gating on XC2
    for (int t = 0; t < 12; t++) begin
      i_clock_source_select[0] = 3'(tab[t][0]);
      i_clock_gate_select[0] = 2'(tab[t][1]);
      for (int c = 0; c < 3; c++) i_route_sel[c] = 2'(tab[t][2]);
      cmd(4);
      repeat (300) tick;
      delta(640, d);
      chk(d, tab[t][3]);
    end
    // inverted fastest clock still counts once per period
    i_clock_source_select[0] = SRC_INT1;
    i_clock_invert[0] = 1'b1;
    cmd(4);
    repeat (300) tick;
    delta(640, d);
    chk(d, 320);
    i_clock_invert[0] = 1'b0;
    // disabled clock ignores triggers; sync restarts every channel
    i_clock_source_select[0] = SRC_INT1;
    cmd(3);
    delta(64, d);
    chk({o_clock_running_flag, d}, 0);
    cmd(4);
    delta(64, d);
    chk(d, 0);
    cmd(5);
    cmd(6);
    chk(o_clock_started, 7);
    repeat (4) tick;
    delta(64, d);
    chk(d, 32);
    // capture loads, read handling and overrun
    i_clock_source_select[0] = SRC_XC0;
    i_first_load_edge[0] = EDGE_RISE;
    i_second_load_edge[0] = EDGE_FALL;
    cmd(4);
    cmd(0);
    for (int p = 0; p < 3; p++) begin
      w = 4 * (2 + {$random(seed)} % 8);
      linea(w);
      chk(16'(o_second_capture_reg[0] - o_first_capture_reg[0]), w / 4);
      chk(o_load_overrun_flag[0], p == 2);
      if (p == 0) cmd(2);
      if (p == 0) cmd(1);
    end
    cmd(0);
    chk(o_load_overrun_flag[0], 0);
    // a load without its partner load never repeats, for every edge code
    for (int e = 0; e < 8; e++) begin
      i_first_load_edge[0] = (e < 4) ? 2'(e) : EDGE_NONE;
      i_second_load_edge[0] = (e < 4) ? EDGE_NONE : 2'(e);
      cmd(4);
      cmd(1);
      cmd(2);
      cmd(0);
      linea(8);
      linea(8);
      chk(o_load_overrun_flag[0], 0);
    end
    // second load halts, then disables, the counter clock
    i_first_load_edge[0] = EDGE_RISE;
    i_second_load_edge[0] = EDGE_FALL;
    i_second_capture_load_halt[0] = 1'b1;
    cmd(4);
    linea(8);
    delta(64, d);
    chk({o_clock_started[0], d}, 0);
    i_second_capture_load_halt[0] = 1'b0;
    i_second_capture_load_disable[0] = 1'b1;
    cmd(4);
    linea(8);
    chk(o_clock_running_flag[0], 0);
    i_second_capture_load_disable[0] = 1'b0;
    cmd(5);
    // compare trigger, then compare disable in waveform mode
    i_clock_source_select[0] = SRC_INT1;
    i_period_compare_reg[0] = 16'(20 + {$random(seed)} % 64);
    i_period_compare_trigger_en[0] = 1'b1;
    cmd(4);
    repeat (400) tick;
    chk(o_counter_value[0] <= i_period_compare_reg[0], 1);
    i_period_compare_trigger_en[0] = 1'b0;
    i_wave_mode[0] = 1'b1;
    i_period_compare_disable[0] = 1'b1;
    tick;
    chk({o_io_line_a_oe[0], o_io_line_b_oe[0]}, 3);
    i_io_line_a_wave = 3'($random(seed));
    i_io_line_b_wave = 3'($random(seed));
    #1;
    chk({o_io_line_a_out[0], o_io_line_b_out[0]},
        {i_io_line_a_wave[0], i_io_line_b_wave[0]});
    cmd(4);
    repeat (200) tick;
    chk(o_clock_running_flag[0], 0);
    {i_wave_mode[0], i_period_compare_disable[0]} = 2'h0;
    cmd(5);
    // rising edge on line b restarts the count
    i_ext_trigger_edge[0] = EDGE_RISE;
    cmd(4);
    repeat (300) tick;
    i_io_line_b_in[0] = 1'b1;
    repeat (4) tick;
    i_io_line_b_in[0] = 1'b0;
    repeat (4) tick;
    chk(o_counter_value[0] < 16'h0008, 1);
    wrap_up();
  end
endmodule
